// file: pic_host_regs.svh
/*
  offsets, field positions, reset values and timing counts for the
  controller that drives an eight-level priority interrupt controller.
  assumes: included by bare name, after the package, by the host module.
*/
`ifndef PIC_HOST_REGS_SVH
`define PIC_HOST_REGS_SVH

`define REG_WR_LOW 4'h0
`define REG_WR_HIGH 4'h1
`define REG_RD_CMD 4'h2
`define REG_ACK_CMD 4'h3
`define REG_CFG 4'h4
`define REG_STATUS 4'h5
`define REG_RDATA 4'h6
`define REG_VEC0 4'h7
`define REG_VEC1 4'h8
`define REG_VEC2 4'h9

`define CFG_CALL_MODE 0
`define CFG_MASTER 1
`define CFG_RESET 2'h2

`define STAT_BUSY 0
`define STAT_INT 1
`define STAT_RD_VALID 2
`define STAT_VEC_VALID 3

`define ACK_PULSES_CALL 2'h3
`define ACK_PULSES_VECTOR 2'h2

`define CLK_PERIOD_NS 5
`define STROBE_NS 50
`define RECOVER_NS 20
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: pic_host_pkg.sv
/*
  types for the interrupt controller host: sequencer states and pin operations.
  assumes: compiled before the host module.
*/
package pic_host_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } seq_state_e;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ,
    OP_ACK
  } pin_op_e;

endpackage : pic_host_pkg

// file: pic_host.sv
/*
  host-side controller for an eight-level priority interrupt controller:
  turns register writes into pin-level write, read and acknowledge cycles.
  assumes: pins of the device arrive asynchronously; software port is
  synchronous to clk and never issues a strobe while busy is set.
*/
// The implementer's own choices: the address map and strobed register access.
`include "pic_host_regs.svh"
module pic_host
  import pic_host_pkg::*;
#(
  parameter int STROBE_CYC = `STROBE_CYC,
  parameter int RECOVER_CYC = `RECOVER_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic ack_vector_strobe_n,
  output logic reg_select_bit,
  output logic [7:0] host_wdata,
  output logic master_slave_select,
  output logic irq_seen,
  input wire logic [7:0] dev_rdata,
  input wire logic rdata_valid,
  input wire logic dev_int
);

  function automatic logic [7:0] cyc8(input int n);
    cyc8 = (n < 1) ? 8'h01 : 8'(n);
  endfunction : cyc8

  function automatic logic [7:0] status_byte(input logic bsy, input logic irq, input logic rdv, input logic vcv);
    status_byte = {4'h0, vcv, rdv, irq, bsy};
  endfunction : status_byte

  seq_state_e state_r, state_nxt;
  pin_op_e op_r, op_nxt;
  logic [7:0] cnt_r;
  logic [1:0] pulses_r;
  logic [1:0] pulse_idx_r;
  logic [1:0] cfg_r;
  logic [7:0] rd_byte_r;
  logic rd_valid_r;
  logic vec_valid_r;
  logic [7:0] vec_r [3];
  logic [7:0] do_m_r, do_s_r;
  logic de_m_r, de_s_r;
  logic int_m_r, int_s_r;
  logic start;
  logic last_strobe;
  logic last_pulse;
  logic cnt_done;

  assign start = wr && state_r == ST_IDLE && addr <= `REG_ACK_CMD;
  assign cnt_done = cnt_r == 8'h01;
  assign last_strobe = state_r == ST_STROBE && cnt_done;
  assign last_pulse = pulse_idx_r == pulses_r - 2'h1;

  // pins are foreign to clk: two stages before any use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      do_m_r <= 8'h00;
      do_s_r <= 8'h00;
    end else if (ce) begin
      do_m_r <= dev_rdata;
      do_s_r <= do_m_r;
    end
  end

  // bus bits may skew in stage one; the long strobe lets them settle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      de_m_r <= 1'b0;
      de_s_r <= 1'b0;
    end else if (ce) begin
      de_m_r <= rdata_valid;
      de_s_r <= de_m_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_m_r <= 1'b0;
      int_s_r <= 1'b0;
    end else if (ce) begin
      int_m_r <= dev_int;
      int_s_r <= int_m_r;
    end
  end

  always_comb begin
    op_nxt = op_r;
    if (start) begin
      unique case (addr)
        `REG_RD_CMD: op_nxt = OP_READ;
        `REG_ACK_CMD: op_nxt = OP_ACK;
        default: op_nxt = OP_WRITE;
      endcase
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (start) state_nxt = ST_SETUP;
      ST_SETUP: state_nxt = ST_STROBE;
      ST_STROBE: if (cnt_done) state_nxt = ST_RECOVER;
      ST_RECOVER: begin
        if (cnt_done) begin
          state_nxt = (op_r == OP_ACK && !last_pulse) ? ST_STROBE : ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      op_r <= OP_WRITE;
    end else if (ce) begin
      state_r <= state_nxt;
      op_r <= op_nxt;
    end
  end

  // reload on every entry, so back-to-back ack pulses each get full width
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
    end else if (ce) begin
      if (state_nxt == ST_STROBE && state_r != ST_STROBE) begin
        cnt_r <= cyc8(STROBE_CYC);
      end else if (state_nxt == ST_RECOVER && state_r != ST_RECOVER) begin
        cnt_r <= cyc8(RECOVER_CYC);
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // pin drive, registered off the next state so strobes align with state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      ack_vector_strobe_n <= 1'b1;
    end else if (ce) begin
      // acknowledge runs with chip select high: the device ignores it there
      chip_select_n <= !(state_nxt != ST_IDLE && op_nxt != OP_ACK);
      write_strobe_n <= !(state_nxt == ST_STROBE && op_nxt == OP_WRITE);
      read_strobe_n <= !(state_nxt == ST_STROBE && op_nxt == OP_READ);
      ack_vector_strobe_n <= !(state_nxt == ST_STROBE && op_nxt == OP_ACK);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_select_bit <= 1'b0;
    end else if (ce && start) begin
      unique case (addr)
        `REG_WR_LOW: reg_select_bit <= 1'b0;
        `REG_WR_HIGH: reg_select_bit <= 1'b1;
        `REG_RD_CMD: reg_select_bit <= wdata[0];
        default: reg_select_bit <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_wdata <= 8'h00;
    end else if (ce && start && addr <= `REG_WR_HIGH) begin
      // command words are passed verbatim: mode changes need no re-init
      host_wdata <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= `CFG_RESET;
    end else if (ce && wr && addr == `REG_CFG) begin
      cfg_r <= wdata[1:0];
    end
  end

  // registered copy, so the pin never glitches while software writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      master_slave_select <= 1'b1;
    end else if (ce) begin
      master_slave_select <= cfg_r[`CFG_MASTER];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulses_r <= `ACK_PULSES_VECTOR;
    end else if (ce && start) begin
      pulses_r <= cfg_r[`CFG_CALL_MODE] ? `ACK_PULSES_CALL : `ACK_PULSES_VECTOR;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_idx_r <= 2'h0;
    end else if (ce) begin
      if (start) begin
        pulse_idx_r <= 2'h0;
      end else if (state_r == ST_RECOVER && cnt_done) begin
        pulse_idx_r <= pulse_idx_r + 2'h1;
      end
    end
  end

  // sample at the strobe's last cycle; only bytes the device marks valid count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_byte_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      if (start && op_nxt == OP_READ) rd_valid_r <= 1'b0;
      if (last_strobe && op_r == OP_READ) begin
        rd_byte_r <= do_s_r;
        rd_valid_r <= de_s_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_valid_r <= 1'b0;
      vec_r[0] <= 8'h00;
      vec_r[1] <= 8'h00;
      vec_r[2] <= 8'h00;
    end else if (ce) begin
      if (start && op_nxt == OP_ACK) vec_valid_r <= 1'b0;
      if (last_strobe && op_r == OP_ACK) begin
        vec_r[pulse_idx_r] <= do_s_r;
        if (last_pulse) vec_valid_r <= de_s_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_seen <= 1'b0;
    end else if (ce) begin
      irq_seen <= int_s_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        unique case (addr)
          `REG_CFG: rdata <= {6'h00, cfg_r};
          `REG_STATUS: rdata <= status_byte(state_r != ST_IDLE, int_s_r, rd_valid_r, vec_valid_r);
          `REG_RDATA: rdata <= rd_byte_r;
          `REG_VEC0: rdata <= vec_r[0];
          `REG_VEC1: rdata <= vec_r[1];
          `REG_VEC2: rdata <= vec_r[2];
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule : pic_host

// file: pic_host_properties.sv
/* pin sequencing checks for pic_host.
   assumes: bound onto pic_host, ce held high. */
module pic_host_chk #(
  parameter int STROBE_CYC = 10,
  parameter int RECOVER_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic ack_vector_strobe_n,
  input wire logic master_slave_select,
  input wire logic irq_seen,
  input wire logic dev_int
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack; !ack_vector_strobe_n |-> chip_select_n; endproperty
  a_ack: assert property (p_ack) else $error("ack with select");
  property p_wr; !write_strobe_n |-> !chip_select_n; endproperty
  a_wr: assert property (p_wr) else $error("write without select");
  property p_rd; !read_strobe_n |-> !chip_select_n; endproperty
  a_rd: assert property (p_rd) else $error("read without select");
  property p_len; $fell(write_strobe_n) || $fell(read_strobe_n)
    |-> ##STROBE_CYC ($rose(write_strobe_n) || $rose(read_strobe_n)); endproperty
  a_len: assert property (p_len) else $error("strobe length");
  property p_alen; $fell(ack_vector_strobe_n) |-> ##STROBE_CYC $rose(ack_vector_strobe_n); endproperty
  a_alen: assert property (p_alen) else $error("ack length");
  property p_rel; $rose(write_strobe_n) || $rose(read_strobe_n) |-> ##RECOVER_CYC $rose(chip_select_n);
  endproperty
  a_rel: assert property (p_rel) else $error("select release");
  property p_ms; $rose(rst_b) |-> master_slave_select; endproperty
  a_ms: assert property (p_ms) else $error("master after reset");
  property p_irq; dev_int [*4] |-> irq_seen; endproperty
  a_irq: assert property (p_irq) else $error("interrupt lost");
endmodule : pic_host_chk
bind pic_host pic_host_chk #(.STROBE_CYC(STROBE_CYC), .RECOVER_CYC(RECOVER_CYC)) i_pic_host_chk (.clk, .rst_b,
  .chip_select_n, .write_strobe_n, .read_strobe_n, .ack_vector_strobe_n, .master_slave_select, .irq_seen, .dev_int);

// file: pic_dev_model.sv
/* behavioural interrupt controller device.
   assumes: pins from pic_host; only the mask command is kept. */
module pic_dev_model (
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic ack_vector_strobe_n,
  input wire logic reg_select_bit,
  input wire logic master_slave_select,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] request_lines,
  output logic [7:0] dev_rdata,
  output logic rdata_valid,
  output logic dev_int,
  output logic [2:0] cascade_id_out,
  output logic cascade_out_valid_n,
  output logic buffer_ctrl_valid_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mask_r = 8'hff;
  logic [7:0] last_r = 8'h00;
  logic [1:0] nack_r = 2'h0;
  logic [7:0] pend;
  logic [2:0] lvl;
  assign pend = request_lines & ~mask_r;
  assign dev_int = |pend;
  // lone master: the winning level stands in for the selected slave id
  assign cascade_id_out = lvl;
  assign cascade_out_valid_n = !(master_slave_select && !ack_vector_strobe_n);
  // unbuffered wiring: the select pin is an input, so buffer control never drives
  assign buffer_ctrl_valid_n = 1'b1;
  always_comb begin
    lvl = 3'h0;
    for (int i = 7; i >= 0; i--) if (pend[i]) lvl = 3'(i);
  end
  always @(posedge write_strobe_n) if (!chip_select_n && reg_select_bit) mask_r <= host_wdata;
  // byte index restarts on any selected access
  always @(negedge chip_select_n or posedge ack_vector_strobe_n) nack_r <= chip_select_n ? nack_r + 2'h1 : 2'h0;
  always_comb begin
    rdata_valid = 1'b1;
    if (!read_strobe_n && !chip_select_n) dev_rdata = reg_select_bit ? mask_r : request_lines;
    else if (!ack_vector_strobe_n) dev_rdata = {nack_r, 3'h0, lvl};
    else begin
      rdata_valid = 1'b0;
      dev_rdata = ~last_r; // released bus never keeps the old byte
    end
  end
  always @(dev_rdata) if (rdata_valid) last_r = dev_rdata;
endmodule : pic_dev_model

// file: test_pic_host.sv
/* bench for pic_host against pic_dev_model.
   assumes: package, header and models compiled first. */
`include "pic_host_regs.svh"
module test_pic_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, ce = 1, wr = 0, rd = 0, cs_n, ws_n, rs_n, as_n, sel, ms, irq, dv, di, casv, bv;
  logic [2:0] cid;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, request_lines = 8'h00, rdata, hw, dd, d;
  int n_mismatch = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  pic_host #(.STROBE_CYC(3), .RECOVER_CYC(1)) i_pic_host (.clk, .rst_b, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .chip_select_n(cs_n), .write_strobe_n(ws_n), .read_strobe_n(rs_n), .ack_vector_strobe_n(as_n),
    .reg_select_bit(sel), .host_wdata(hw), .master_slave_select(ms), .irq_seen(irq), .dev_rdata(dd),
    .rdata_valid(dv), .dev_int(di));
  pic_dev_model i_pic_dev_model (.chip_select_n(cs_n), .write_strobe_n(ws_n), .read_strobe_n(rs_n),
    .ack_vector_strobe_n(as_n), .reg_select_bit(sel), .master_slave_select(ms), .host_wdata(hw), .request_lines,
    .dev_rdata(dd), .rdata_valid(dv), .dev_int(di), .cascade_id_out(cid), .cascade_out_valid_n(casv),
    .buffer_ctrl_valid_n(bv));
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rv(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    if (nm != "") chk(nm, e, d);
  endtask : rv
  // bounded poll, a stuck busy counts once
  task wait_idle;
    for (int i = 0; i < 40; i++) begin
      rv(`REG_STATUS, 8'h00, "");
      if (d[`STAT_BUSY] === 1'b0) return;
    end
    chk("busy", 8'h00, 8'h01);
  endtask : wait_idle
  task cmd(input logic [3:0] a, input logic [7:0] v);
    wr_reg(a, v);
    wait_idle;
  endtask : cmd
  task t_write;
    chk("ms", 8'h01, {7'h0, ms});
    rv(`REG_CFG, 8'h02, "cfg");
    wr_reg(`REG_WR_HIGH, 8'hf0);
    cmd(`REG_WR_LOW, 8'h33);
    chk("hw", 8'hf0, hw);
    chk("sel", 8'h01, {7'h0, sel});
  endtask : t_write
  task t_status;
    @(posedge clk);
    request_lines <= 8'h0a;
    cmd(`REG_RD_CMD, 8'h01);
    rv(`REG_RDATA, 8'hf0, "mask");
    cmd(`REG_RD_CMD, 8'h00);
    rv(`REG_RDATA, 8'h0a, "pend");
    rv(`REG_STATUS, 8'h06, "stat");
    chk("irq", 8'h01, {7'h0, irq});
    cmd(`REG_WR_HIGH, 8'hff);
    repeat (4) @(posedge clk);
    chk("irq", 8'h00, {7'h0, irq});
  endtask : t_status
  task t_ack;
    cmd(`REG_WR_HIGH, 8'h02);
    cmd(`REG_CFG, 8'h02);
    wr_reg(`REG_ACK_CMD, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("cas", 8'h03, {4'h0, casv, cid});
    chk("buf", 8'h01, {7'h0, bv});
    wait_idle;
    rv(`REG_VEC0, 8'h03, "v0");
    rv(`REG_VEC1, 8'h43, "v1");
    cmd(`REG_WR_HIGH, 8'h00);
    cmd(`REG_CFG, 8'h01);
    chk("ms", 8'h00, {7'h0, ms});
    cmd(`REG_ACK_CMD, 8'h00);
    rv(`REG_VEC0, 8'h01, "v0");
    rv(`REG_VEC2, 8'h81, "v2");
    rv(`REG_STATUS, 8'h0e, "stat");
    rv(4'hf, 8'h00, "unmapped");
  endtask : t_ack
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_write;
    t_status;
    t_ack;
    summarize;
  end
  initial begin
    #20000;
    n_mismatch++;
    summarize;
  end
endmodule : test_pic_host
